/* File: design/cfsp_port.sv */
// Purpose: four-wire serial configuration port with register storage
// Assumes: one 100 MHz clock; serial clock handled as a sampled signal
// Notes:   register contents survive every reset and have no defaults
`timescale 1ns/10ps

module cfsp_port
  import cfsp_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // serial configuration pins
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    rd_wr,
  input  wire logic                    serial_data_line_in,
  output logic                         serial_data_line_out,
  output logic                         serial_data_line_oe,
  // master reset pin and function enables
  input  wire logic                    master_reset_n,
  output logic                         tx_enable,
  output logic                         rx_enable,
  output logic                         standby,
  // divided clock enables
  output logic                         clk_div2_en,
  output logic                         clk_div4_en,
  // configuration read-back for the rest of the device
  input  wire logic [REG_IDX_BITS-1:0] cfg_index,
  output logic      [DATA_BITS-1:0]    cfg_data
);
  logic [3:0]              pins_s;
  logic                    sclk_s;
  logic                    cs_n_s;
  logic                    rw_s;
  logic                    sd_s;
  logic                    sclk_d_reg;
  logic                    rise;
  cfsp_state_t             state_reg;
  logic [2:0]              cnt_reg;
  logic [DATA_BITS-1:0]    shift_reg;
  logic [DATA_BITS-1:0]    rd_shift_reg;
  logic [ADDR_BITS-1:0]    addr_reg;
  logic [ADDR_BITS-1:0]    addr_next;
  logic [DATA_BITS-1:0]    wr_data_next;
  logic                    wr_en;
  logic [1:0]              div_reg;
  logic [DATA_BITS-1:0]    cfg_mem [REG_COUNT];

  cfsp_sync #(
    .WIDTH (4)
  ) cfsp_sync_inst (
    .clk (clk),
    .rst (rst),
    // select enters inverted so a cleared synchroniser reads as deselected
    .d   ({sclk, ~cs_n, rd_wr, serial_data_line_in}),
    .q   (pins_s)
  );

  assign sclk_s = pins_s[3];
  assign cs_n_s = ~pins_s[2];
  assign rw_s   = pins_s[1];
  assign sd_s   = pins_s[0];

  // edge detect on the synchronised serial clock
  // sclk idles low, so the cleared history bit gives no false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end

  assign rise         = sclk_s & ~sclk_d_reg;
  assign addr_next    = {shift_reg[DATA_BITS-2:0], sd_s};
  assign wr_data_next = {shift_reg[DATA_BITS-2:0], sd_s};
  // write strobe: sixteenth rising edge of a write frame
  assign wr_en        = ~cs_n_s & rise & (state_reg == CFSP_DATA)
                        & (cnt_reg == LAST_BIT) & ~rw_s;

  // serial state machine
  always_ff @(posedge clk) begin
    if (rst || cs_n_s) begin
      state_reg    <= CFSP_IDLE;
      cnt_reg      <= CNT_RESET;
      shift_reg    <= '0;
      rd_shift_reg <= '0;
      addr_reg     <= '0;
    end else begin
      case (state_reg)
        CFSP_IDLE: begin
          state_reg <= CFSP_ADDR;
          cnt_reg   <= CNT_RESET;
        end
        CFSP_ADDR: begin
          if (rise) begin
            shift_reg <= addr_next;
            cnt_reg   <= cnt_reg + 3'h1;
            if (cnt_reg == LAST_BIT) begin
              addr_reg     <= addr_next;
              rd_shift_reg <= cfg_mem[addr_next[ADDR_BITS-1:1]];
              state_reg    <= CFSP_DATA;
              cnt_reg      <= CNT_RESET;
            end
          end
        end
        CFSP_DATA: begin
          if (rise) begin
            shift_reg    <= wr_data_next;
            rd_shift_reg <= {rd_shift_reg[DATA_BITS-2:0], 1'b0};
            cnt_reg      <= cnt_reg + 3'h1;
            if (cnt_reg == LAST_BIT) begin
              state_reg <= CFSP_DONE;
            end
          end
        end
        CFSP_DONE: begin
          // further edges are ignored until select goes high
          state_reg <= CFSP_DONE;
        end
        default: begin
          state_reg <= CFSP_IDLE;
        end
      endcase
    end
  end

  // read data line: the next bit appears after each rising edge
  // first bit comes straight from storage, the rest from the shift register
  always_ff @(posedge clk) begin
    if (rst || cs_n_s) begin
      serial_data_line_out <= 1'b0;
    end else if (rise && state_reg == CFSP_ADDR && cnt_reg == LAST_BIT) begin
      serial_data_line_out <=
        cfg_mem[addr_next[ADDR_BITS-1:1]][DATA_BITS-1];
    end else if (rise && state_reg == CFSP_DATA) begin
      serial_data_line_out <= rd_shift_reg[DATA_BITS-2];
    end
  end

  // drive only while selected and reading
  // follows the pins about three clocks late, like the serial path
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_data_line_oe <= 1'b0;
    end else begin
      serial_data_line_oe <= ~cs_n_s & rw_s;
    end
  end

  // configuration storage: no reset, no preset values
  // the reserved low address bit is dropped from the index
  always_ff @(posedge clk) begin
    if (wr_en) begin
      cfg_mem[addr_reg[ADDR_BITS-1:1]] <= wr_data_next;
    end
  end

  always_ff @(posedge clk) begin
    cfg_data <= cfg_mem[cfg_index];
  end

  // transmit enable and standby follow master reset only
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_enable <= 1'b0;
      standby   <= 1'b1;
    end else begin
      tx_enable <= master_reset_n;
      standby   <= ~master_reset_n;
    end
  end

  // receive side kept apart: select never reaches it
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_enable <= 1'b0;
    end else begin
      rx_enable <= master_reset_n;
    end
  end

  // free-running divider count, wraps every four clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= DIV_RESET;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end

  // divide-by-two and divide-by-four enables
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_div2_en <= 1'b0;
      clk_div4_en <= 1'b0;
    end else begin
      clk_div2_en <= div_reg[0];
      clk_div4_en <= (div_reg == DIV4_LAST);
    end
  end
endmodule

/* File: design/cfsp_pkg.sv */
// Purpose: constants for the four-wire serial configuration port
// Assumes: 100 MHz system clock, serial pins sampled on that clock
// Notes:   shared by the port top and its synchroniser
package cfsp_pkg;
  localparam int          ADDR_BITS     = 8;
  localparam int          DATA_BITS     = 8;
  localparam int          REG_IDX_BITS  = 7;
  localparam int          REG_COUNT     = 128;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [2:0]  CNT_RESET     = 3'h0;
  localparam logic [1:0]  DIV_RESET     = 2'h0;
  localparam logic [1:0]  DIV4_LAST     = 2'h3;
  localparam int          SYNC_STAGES   = 2;
  // controller-side serial clock limit, kept for reference by the bench
  localparam int          SCLK_MAX_HZ   = 11000000;
  localparam int          SYS_CLK_HZ    = 100000000;
  localparam int          MCLK_NOM_HZ   = 44000000;

  typedef enum logic [1:0] {
    CFSP_IDLE = 2'b00,
    CFSP_ADDR = 2'b01,
    CFSP_DATA = 2'b10,
    CFSP_DONE = 2'b11
  } cfsp_state_t;
endpackage

/* File: design/cfsp_sync.sv */
// Purpose: two-flop synchroniser for asynchronous serial pins
// Assumes: inputs may change at any time relative to clk
// Notes:   only the second stage is visible outside
`timescale 1ns/10ps
module cfsp_sync
  import cfsp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

/* File: tb/cfsp_port_monitor.sv */
// Purpose: assertions on cfsp_port pins
// Assumes: pins act within 3 clocks. Notes: bound below
`timescale 1ns/10ps
module cfsp_port_monitor (
  // clock, reset and watched pins
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_wr,
  input wire logic serial_data_line_oe,
  input wire logic master_reset_n,
  input wire logic tx_enable,
  input wire logic standby,
  input wire logic clk_div2_en,
  input wire logic clk_div4_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_write: assert property (!rd_wr [*5] |-> !serial_data_line_oe)
    else $error("oe on write");
  a_oe_read: assert property ((!cs_n && rd_wr) [*5] |->
    serial_data_line_oe) else $error("no oe on read");
  a_oe_deselect: assert property (cs_n [*5] |-> !serial_data_line_oe)
    else $error("oe deselected");
  a_tx_follows: assert property (!$past(rst) |->
    tx_enable == $past(master_reset_n)) else $error("tx enable");
  a_standby_follows: assert property (!$past(rst) |->
    standby != $past(master_reset_n)) else $error("standby");
  a_tx_not_standby: assert property (tx_enable != standby)
    else $error("tx vs standby");
  a_half_rate: assert property (clk_div2_en |=>
    !clk_div2_en ##1 clk_div2_en) else $error("div2 period");
  a_quarter_rate: assert property (clk_div4_en |=>
    !clk_div4_en [*3] ##1 clk_div4_en) else $error("div4 period");
endmodule
bind cfsp_port cfsp_port_monitor cfsp_port_monitor_inst (.*);

/* File: tb/cfsp_ctrl_model.sv */
// Purpose: controller model for the serial port
// Assumes: pins change on falling bench clock edges, sclk low between frames
// Notes:   sel low keeps select high to show that the port ignores the pins
`timescale 1ns/10ps
module cfsp_ctrl_model (
  // bench clock
  input  wire logic clk,
  // serial pins
  output logic      sclk   = 1'b0,
  output logic      cs_n   = 1'b1,
  output logic      rd_wr  = 1'b0,
  output logic      sd_out = 1'b1,
  input  wire logic sd_line
);
  // serial clock phase in bench clocks: about 8.3 MHz, under the limit
  localparam int HALF = 6;

  task automatic xfer(input logic sel, input logic rd, input logic [15:0] w,
                      input int n, output logic [7:0] q);
    q = 8'h00;
    @(negedge clk);
    cs_n = ~sel;
    repeat (HALF) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      rd_wr  = rd && i >= 7;
      sd_out = (rd && i >= 8) ? ~sd_out : w[15-i];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
      if (rd && i >= 7 && i < 15) q = {q[6:0], sd_line};
    end
    repeat (HALF) @(negedge clk);
    cs_n   = 1'b1;
    rd_wr  = 1'b0;
    sd_out = ~sd_out;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

/* File: tb/cfsp_port_tb_top.sv */
// Purpose: self-checking bench for cfsp_port
// Assumes: cfsp_ctrl_model drives the serial pins. Notes: none
`timescale 1ns/10ps
module cfsp_port_tb_top;
  logic       clk = 1'b0, rst = 1'b1, mrst_n = 1'b1, sdl, ctl_sd;
  logic       sclk, cs_n, rd_wr, dut_sd, dut_oe;
  logic [6:0] idx = 7'h00;
  logic [7:0] cfg_data, rd_val;
  logic       tx_en, rx_en, stby;
  int         n_fail = 0, total_checks = 0;
  assign sdl = dut_oe ? dut_sd : ctl_sd;
  cfsp_port cfsp_port_inst (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .rd_wr(rd_wr), .serial_data_line_in(sdl), .serial_data_line_out(dut_sd),
    .serial_data_line_oe(dut_oe), .master_reset_n(mrst_n),
    .tx_enable(tx_en), .rx_enable(rx_en), .standby(stby), .clk_div2_en(),
    .clk_div4_en(), .cfg_index(idx), .cfg_data(cfg_data));
  cfsp_ctrl_model cfsp_ctrl_model_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n),
    .rd_wr(rd_wr), .sd_out(ctl_sd), .sd_line(sdl));
  initial forever #5 clk = ~clk;
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) n_fail++;
    if (g !== e) $display("unexpected %s: expected %h seen %h", s, e, g);
  endtask
  task automatic peek(logic [6:0] i, logic [7:0] e);
    @(negedge clk) idx = i;
    repeat (2) @(negedge clk);
    chk("cfg_data", e, cfg_data);
  endtask
  task automatic t_rw();
    for (int k = 0; k < 3; k++) begin
      logic [7:0] d = 8'hc1 + 8'(23 * k);
      cfsp_ctrl_model_inst.xfer(1'b1, 1'b0, {8'(8'h41 + 2 * k), d}, 16,
                                rd_val);
      peek(7'(7'h20 + k), d);
      cfsp_ctrl_model_inst.xfer(1'b1, 1'b1, {8'(8'h40 + 2 * k), d}, 16,
                                rd_val);
      chk("read data", d, rd_val);
    end
  endtask
  task automatic t_mrst();
    @(negedge clk) mrst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("enables", 8'h01, {5'h00, tx_en, rx_en, stby});
    peek(7'h22, 8'hef);
    mrst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("enables", 8'h06, {5'h00, tx_en, rx_en, stby});
  endtask
  task automatic t_abort();
    cfsp_ctrl_model_inst.xfer(1'b1, 1'b0, 16'h443c, 15, rd_val);
    peek(7'h22, 8'hef);
    cfsp_ctrl_model_inst.xfer(1'b1, 1'b0, 16'h443c, 16, rd_val);
    peek(7'h22, 8'h3c);
  endtask
  task automatic t_desel();
    cfsp_ctrl_model_inst.xfer(1'b0, 1'b0, 16'h4455, 16, rd_val);
    peek(7'h22, 8'h3c);
    chk("enables", 8'h06, {5'h00, tx_en, rx_en, stby});
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #200 rst = 1'b0;
    t_rw();
    t_mrst();
    t_abort();
    t_desel();
    print_verdict();
  end
  initial begin
    #100000 n_fail++;
    print_verdict();
  end
endmodule
